// >>> rtl/mdp_mmu_check.sv
// Top: register file, abort priority, fault recording and response
`timescale 1ns/1ns
module mdp_mmu_check
	import mdp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Coprocessor register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [3:0]  reg_sel,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	// Control bits
	input  wire logic        mmu_en,
	input  wire logic        sys_prot,
	input  wire logic        align_en,
	input  wire logic        cache_en,
	input  wire logic        wbuf_en,
	// Access request from the core
	input  wire logic        req_valid,
	input  wire logic [31:0] req_va,
	input  wire logic        req_write,
	input  wire logic        req_data,
	input  wire logic        req_super,
	input  wire logic        req_word,
	input  wire logic [31:0] l1_desc,
	input  wire logic [31:0] l2_desc,
	// External abort sources
	input  wire logic        wbuf_err,
	input  wire logic        lf_err,
	input  wire logic        lf_word0,
	input  wire logic        ext_err,
	input  wire logic        walk_err_l1,
	input  wire logic        walk_err_l2,
	input  wire logic        err_page,
	// Response to the core and bus
	output logic             resp_valid,
	output logic             resp_abort,
	output logic             data_abort,
	output logic             prefetch_abort,
	output logic             mem_start,
	output logic      [31:0] resp_pa,
	output logic             resp_cacheable,
	output logic             resp_bufferable,
	output logic             resp_updateable,
	output logic             abort_info_valid
);
	logic [31:0] domain_rights;       // Sixteen domain fields
	logic [7:0]  abort_cause;         // Domain and fault code
	logic [31:0] abort_address;       // Faulting virtual address
	logic        wb_pending;          // Write-buffer error waiting
	logic [31:0] next_domain_rights;
	logic [7:0]  next_abort_cause;
	logic [31:0] next_abort_address;
	logic        next_wb_pending;
	logic [31:0] next_reg_rdata;
	logic        next_resp_valid;
	logic        next_resp_abort;
	logic        next_data_abort;
	logic        next_prefetch_abort;
	logic        next_mem_start;
	logic [31:0] next_resp_pa;
	logic        next_resp_c;
	logic        next_resp_b;
	logic        next_resp_u;
	logic        next_info_valid;
	logic        align_fault;         // Misaligned data word
	logic        hi_hit;              // A higher source fired
	logic [3:0]  hi_code;             // Its code
	logic        fault;               // Any abort this access
	logic [3:0]  fault_code;          // Winning code

	mdp_chk_if chk ();

	// Feed the checker
	assign chk.va       = req_va;
	assign chk.l1       = l1_desc;
	assign chk.l2       = l2_desc;
	assign chk.write    = req_write;
	assign chk.supv     = req_super;
	assign chk.s_bit    = sys_prot;
	assign chk.mmu_en   = mmu_en;
	assign chk.cache_en = cache_en;
	assign chk.wbuf_en  = wbuf_en;
	assign chk.rights   = domain_rights;

	// Descriptor checker
	mdp_desc_check u_check (
		.c (chk)
	);

	// Abort priority and next state
	always_comb
	begin
		align_fault = align_en && req_data && req_word && (req_va[1:0] != 2'h0);
		hi_hit      = 1'b1;
		if (wb_pending && req_data)
			hi_code = FC_WBUF;
		else if (lf_err)
			hi_code = err_page ? FC_LF_PAGE : FC_LF_SEC;
		else if (ext_err)
			hi_code = err_page ? FC_BUS_PAGE : FC_BUS_SEC;
		else if (align_fault)
			hi_code = FC_ALIGN;
		else if (walk_err_l1)
			hi_code = FC_WALK_L1;
		else if (walk_err_l2)
			hi_code = FC_WALK_L2;
		else
		begin
			hi_hit  = 1'b0;
			hi_code = FC_WBUF;
		end
		fault      = hi_hit || chk.fault;
		fault_code = hi_hit ? hi_code : chk.code;
		// Software writes
		next_domain_rights = domain_rights;
		next_abort_cause   = abort_cause;
		next_abort_address = abort_address;
		next_info_valid    = abort_info_valid;
		if (reg_wr)
		begin
			case (reg_sel)
				REG_DOMAIN: next_domain_rights = reg_wdata;
				REG_CAUSE:  next_abort_cause   = reg_wdata[7:0];
				REG_ADDR:   next_abort_address = reg_wdata;
				default:    next_domain_rights = domain_rights;
			endcase
		end
		// error held until a data access can take it, set wins
		next_wb_pending = wbuf_err || (wb_pending && !(req_valid && req_data));
		// data abort recording wins over a software write
		if (req_valid && req_data && fault)
		begin
			next_abort_cause   = {chk.dom, fault_code};
			next_abort_address = req_va;
			// linefetch detail trusted only on word 0
			next_info_valid    = !(lf_err && !lf_word0 && fault_code[3:1] != 3'h0);
		end
		// Register read data
		case (reg_sel)
			REG_DOMAIN: next_reg_rdata = domain_rights;
			REG_CAUSE:  next_reg_rdata = {24'h0, abort_cause};
			REG_ADDR:   next_reg_rdata = abort_address;
			default:    next_reg_rdata = 32'h0;
		endcase
		if (!reg_rd)
			next_reg_rdata = reg_rdata;
		// abort the access on any fault
		next_resp_valid     = req_valid;
		next_resp_abort     = req_valid && fault;
		// fetch aborts only tag the instruction
		next_data_abort     = req_valid && fault && req_data;
		next_prefetch_abort = req_valid && fault && !req_data;
		// no external cycle for faulted access
		next_mem_start      = req_valid && !fault;
		// address only after a clean check
		next_resp_pa        = next_mem_start ? chk.pa : 32'h0;
		next_resp_c         = next_mem_start && chk.cacheable;
		next_resp_b         = next_mem_start && chk.bufferable;
		next_resp_u         = next_mem_start && chk.updateable;
	end

	// State registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			domain_rights    <= DOMAIN_RST;
			abort_cause      <= CAUSE_RST;
			abort_address    <= ADDR_RST;
			wb_pending       <= 1'b0;
			reg_rdata        <= 32'h0;
			resp_valid       <= 1'b0;
			resp_abort       <= 1'b0;
			data_abort       <= 1'b0;
			prefetch_abort   <= 1'b0;
			mem_start        <= 1'b0;
			resp_pa          <= 32'h0;
			resp_cacheable   <= 1'b0;
			resp_bufferable  <= 1'b0;
			resp_updateable  <= 1'b0;
			abort_info_valid <= 1'b1;
		end
		else
		begin
			domain_rights    <= next_domain_rights;
			abort_cause      <= next_abort_cause;
			abort_address    <= next_abort_address;
			wb_pending       <= next_wb_pending;
			reg_rdata        <= next_reg_rdata;
			resp_valid       <= next_resp_valid;
			resp_abort       <= next_resp_abort;
			data_abort       <= next_data_abort;
			prefetch_abort   <= next_prefetch_abort;
			mem_start        <= next_mem_start;
			resp_pa          <= next_resp_pa;
			resp_cacheable   <= next_resp_c;
			resp_bufferable  <= next_resp_b;
			resp_updateable  <= next_resp_u;
			abort_info_valid <= next_info_valid;
		end
	end

	// Helpers for the checks below
	logic [1:0] h_dfield;
	logic       h_data_clean;
	assign h_dfield     = domain_rights[{l1_desc[L1_DOM_LSB +: 4], 1'b0} +: 2];
	assign h_data_clean = req_valid && req_data && mmu_en && !hi_hit && !reg_wr;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_no_start;
		resp_abort |-> !mem_start && resp_pa == 32'h0;
	endproperty
	a_no_start: assert property (p_no_start) else $error("aborted access started");

	property p_fetch_silent;
		(req_valid && !req_data && !reg_wr && !(wb_pending && req_data)) |=> $stable(abort_cause) && $stable(abort_address);
	endproperty
	a_fetch_silent: assert property (p_fetch_silent) else $error("fetch updated fault registers");

	property p_record;
		(req_valid && req_data && fault) |=> data_abort && abort_address == $past(req_va);
	endproperty
	a_record: assert property (p_record) else $error("faulting address not recorded");

	property p_section_pa;
		(req_valid && mmu_en && l1_desc[1:0] == L1_SECTION && !fault) |=>
			mem_start && resp_pa[31:20] == $past(l1_desc[31:20]) && resp_pa[19:0] == $past(req_va[19:0]);
	endproperty
	a_section_pa: assert property (p_section_pa) else $error("section address wrong");

	property p_dom_none;
		(h_data_clean && l1_desc[1:0] == L1_SECTION && h_dfield == DOM_NONE) |=> abort_cause == {$past(l1_desc[8:5]), FC_DOM_SEC};
	endproperty
	a_dom_none: assert property (p_dom_none) else $error("domain fault not recorded");

	property p_manager;
		(req_valid && mmu_en && l1_desc[1:0] == L1_SECTION && h_dfield == DOM_MANAGER && !hi_hit) |=> resp_valid && !resp_abort;
	endproperty
	a_manager: assert property (p_manager) else $error("manager domain faulted");

	property p_sec_invalid;
		(h_data_clean && l1_desc[1:0] == L1_INVALID) |=> abort_cause[3:0] == FC_TR_SEC && abort_cause[7:4] == $past(l1_desc[8:5]);
	endproperty
	a_sec_invalid: assert property (p_sec_invalid) else $error("section translation fault wrong");

	property p_page_invalid;
		(h_data_clean && l1_desc[1:0] == L1_PAGE && l2_desc[1:0] == 2'h0) |=> abort_cause[3:0] == FC_TR_PAGE;
	endproperty
	a_page_invalid: assert property (p_page_invalid) else $error("page translation fault wrong");

	property p_bus_over_align;
		(req_valid && req_data && ext_err && !lf_err && !wb_pending && align_fault && !reg_wr) |=>
			abort_cause[3:0] == ($past(err_page) ? FC_BUS_PAGE : FC_BUS_SEC);
	endproperty
	a_bus_over_align: assert property (p_bus_over_align) else $error("priority order broken");

	property p_wb_next;
		(wb_pending && req_valid && req_data && !reg_wr) |=> data_abort && abort_cause[3:0] == FC_WBUF;
	endproperty
	a_wb_next: assert property (p_wb_next) else $error("write-buffer error lost");

	c_section_ok: cover property (req_valid && mmu_en && l1_desc[1:0] == L1_SECTION ##1 mem_start);
	c_page_perm: cover property (req_valid && req_data && chk.code == FC_PERM_PG && chk.fault ##1 data_abort);
	c_prefetch: cover property (req_valid && !req_data && fault ##1 prefetch_abort);
endmodule

// >>> rtl/mdp_pkg.sv
// Constants for the descriptor decode and permission check block
package mdp_pkg;
	// Descriptor type codes in bits 1:0
	localparam logic [1:0] L1_INVALID = 2'h0;
	localparam logic [1:0] L1_PAGE    = 2'h1;
	localparam logic [1:0] L1_SECTION = 2'h2;
	localparam logic [1:0] L2_LARGE   = 2'h1;
	localparam logic [1:0] L2_SMALL   = 2'h2;
	// Domain control field codes
	localparam logic [1:0] DOM_NONE    = 2'h0;
	localparam logic [1:0] DOM_CLIENT  = 2'h1;
	localparam logic [1:0] DOM_RSVD    = 2'h2;
	localparam logic [1:0] DOM_MANAGER = 2'h3;
	// Permission field codes
	localparam logic [1:0] AP_NONE    = 2'h0;
	localparam logic [1:0] AP_SUPER   = 2'h1;
	localparam logic [1:0] AP_USER_RO = 2'h2;
	// Fault codes, highest priority first
	localparam logic [3:0] FC_WBUF     = 4'h0;
	localparam logic [3:0] FC_LF_SEC   = 4'h4;
	localparam logic [3:0] FC_LF_PAGE  = 4'h6;
	localparam logic [3:0] FC_BUS_SEC  = 4'h8;
	localparam logic [3:0] FC_BUS_PAGE = 4'ha;
	localparam logic [3:0] FC_ALIGN    = 4'h1;
	localparam logic [3:0] FC_WALK_L1  = 4'hc;
	localparam logic [3:0] FC_WALK_L2  = 4'he;
	localparam logic [3:0] FC_TR_SEC   = 4'h5;
	localparam logic [3:0] FC_TR_PAGE  = 4'h7;
	localparam logic [3:0] FC_DOM_SEC  = 4'h9;
	localparam logic [3:0] FC_DOM_PAGE = 4'hb;
	localparam logic [3:0] FC_PERM_SEC = 4'hd;
	localparam logic [3:0] FC_PERM_PG  = 4'hf;
	// Descriptor field positions
	localparam int L1_B_BIT       = 2;
	localparam int L1_C_BIT       = 3;
	localparam int L1_U_BIT       = 4;
	localparam int L1_DOM_LSB     = 5;
	localparam int L1_AP_LSB      = 10;
	localparam int SEC_BASE_LSB   = 20;
	localparam int L2_B_BIT       = 2;
	localparam int L2_C_BIT       = 3;
	localparam int L2_AP_LSB      = 4;
	localparam int SMALL_BASE_LSB = 12;
	localparam int LARGE_BASE_LSB = 16;
	localparam int SMALL_SUB_LSB  = 10;
	localparam int LARGE_SUB_LSB  = 14;
	// Status register layout
	localparam int CAUSE_DOM_LSB  = 4;
	// Register selects on the coprocessor port
	localparam logic [3:0] REG_DOMAIN = 4'h3;
	localparam logic [3:0] REG_CAUSE  = 4'h5;
	localparam logic [3:0] REG_ADDR   = 4'h6;
	// Reset values
	localparam logic [31:0] DOMAIN_RST = 32'h0;
	localparam logic [7:0]  CAUSE_RST  = 8'h00;
	localparam logic [31:0] ADDR_RST   = 32'h0;
endpackage

// >>> rtl/mdp_chk_if.sv
// Connection between the fault recorder and the descriptor checker
`timescale 1ns/1ns
interface mdp_chk_if;
	import mdp_pkg::*;
	logic [31:0] va;        // Virtual address
	logic [31:0] l1;        // First-level descriptor
	logic [31:0] l2;        // Second-level entry
	logic        write;     // Write access
	logic        supv;      // Supervisor privilege
	logic        s_bit;     // System protection bit
	logic        mmu_en;    // Translation on
	logic        cache_en;  // Cache on
	logic        wbuf_en;   // Write buffer on
	logic [31:0] rights;    // Domain control fields
	logic        fault;     // Translation, domain or permission fault
	logic [3:0]  code;      // Fault code
	logic [3:0]  dom;       // Domain number
	logic [31:0] pa;        // Physical address
	logic        cacheable; // Gated attributes
	logic        bufferable;
	logic        updateable;
	modport requester (output va, l1, l2, write, supv, s_bit, mmu_en, cache_en, wbuf_en, rights,
		input fault, code, dom, pa, cacheable, bufferable, updateable);
	modport decider (input va, l1, l2, write, supv, s_bit, mmu_en, cache_en, wbuf_en, rights,
		output fault, code, dom, pa, cacheable, bufferable, updateable);
endinterface

// >>> rtl/mdp_desc_check.sv
// Descriptor decode, address formation and domain/permission check
`timescale 1ns/1ns
module mdp_desc_check
	import mdp_pkg::*;
(
	// Request in, verdict out
	mdp_chk_if.decider c
);
	logic [3:0] dom;     // Selected domain
	logic [1:0] dfield;  // Its control field
	logic [1:0] ap;      // Permission field in use
	logic [1:0] sub;     // Quarter-page index
	logic [3:0] ap_idx;  // Bit offset of the sub-region field
	logic       is_page; // Page mapping
	logic       tr_bad;  // Descriptor invalid

	// Permission table: supervisor/user against read/write
	function automatic logic ap_ok(input logic [1:0] a, input logic s, input logic sup, input logic wr);
		case (a)
			AP_NONE:    ap_ok = s && sup && !wr;
			AP_SUPER:   ap_ok = sup;
			AP_USER_RO: ap_ok = sup || !wr;
			default:    ap_ok = 1'b1;
		endcase
	endfunction

	// Whole check, combinational
	always_comb
	begin
		dom          = c.l1[L1_DOM_LSB +: 4];
		dfield       = c.rights[{dom, 1'b0} +: 2];
		ap           = c.l1[L1_AP_LSB +: 2];
		sub          = 2'h0;
		ap_idx       = 4'h0;
		is_page      = 1'b0;
		tr_bad       = 1'b0;
		c.fault      = 1'b0;
		c.code       = FC_TR_SEC;
		c.dom        = dom;
		c.pa         = c.va;
		c.cacheable  = 1'b0;
		c.bufferable = 1'b0;
		c.updateable = 1'b0;
		if (c.mmu_en)
		begin
			case (c.l1[1:0])
				L1_SECTION:
				begin
					c.pa = {c.l1[31:SEC_BASE_LSB], c.va[SEC_BASE_LSB-1:0]};
					c.updateable = c.l1[L1_U_BIT] && c.cache_en;
					c.cacheable  = c.l1[L1_C_BIT] && c.cache_en;
					c.bufferable = c.l1[L1_B_BIT] && c.wbuf_en;
				end
				L1_PAGE:
				begin
					is_page      = 1'b1;
					c.updateable = c.l1[L1_U_BIT] && c.cache_en;
					c.cacheable  = c.l2[L2_C_BIT] && c.cache_en;
					c.bufferable = c.l2[L2_B_BIT] && c.wbuf_en;
					case (c.l2[1:0])
						L2_SMALL:
						begin
							c.pa = {c.l2[31:SMALL_BASE_LSB], c.va[SMALL_BASE_LSB-1:0]};
							sub  = c.va[SMALL_SUB_LSB +: 2];
						end
						L2_LARGE:
						begin
							c.pa = {c.l2[31:LARGE_BASE_LSB], c.va[LARGE_BASE_LSB-1:0]};
							sub  = c.va[LARGE_SUB_LSB +: 2];
						end
						default:
						begin
							tr_bad = 1'b1;
							c.code = FC_TR_PAGE;
						end
					endcase
					ap_idx = {1'b0, sub, 1'b0};
					ap     = c.l2[L2_AP_LSB + ap_idx +: 2];
				end
				default:
				begin
					tr_bad = 1'b1;
					c.code = FC_TR_SEC;
				end
			endcase
			if (tr_bad)
			begin
				c.fault = 1'b1;
			end
			else if (dfield == DOM_NONE || dfield == DOM_RSVD)
			begin
				c.fault = 1'b1;
				c.code  = is_page ? FC_DOM_PAGE : FC_DOM_SEC;
			end
			else if (dfield == DOM_CLIENT && !ap_ok(ap, c.s_bit, c.supv, c.write))
			begin
				c.fault = 1'b1;
				c.code  = is_page ? FC_PERM_PG : FC_PERM_SEC;
			end
		end
	end
endmodule

// >>> tb/mdp_core_model.sv
// Behavioural processor core that presents accesses to the checker
`timescale 1ns/1ns
module mdp_core_model
(
	// Clock
	input  wire logic        clk,
	// Access request and its descriptors
	output logic             req_valid,
	output logic      [31:0] req_va,
	output logic             req_write,
	output logic             req_data,
	output logic             req_super,
	output logic             req_word,
	output logic      [31:0] l1_desc,
	output logic      [31:0] l2_desc
);
	// Idle at time zero
	initial
	begin
		req_valid = 1'b0;
		{req_va, l1_desc, l2_desc} = '0;
		{req_word, req_write, req_data, req_super} = 4'h0;
	end

	// One access held over one taking edge; kind is word, write, data, super
	// direction, kind, privilege
	task automatic issue(input logic [31:0] va, l1, l2, input logic [3:0] kind);
		@(posedge clk);
		#1;
		req_valid = 1'b1;
		req_va = va;
		l1_desc = l1;
		l2_desc = l2;
		{req_word, req_write, req_data, req_super} = kind;
		@(posedge clk);
		#1;
		// Released lines flip so a stale value cannot pass
		req_valid = 1'b0;
		req_va = ~req_va;
		l1_desc = ~l1_desc;
		l2_desc = ~l2_desc;
	endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the descriptor and permission checker
`timescale 1ns/1ns
module tb_top;
	import mdp_pkg::*;
	// Clock, reset and register port
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [3:0]  reg_sel = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	// Control bits and abort sources
	logic        mmu_en = 1'b1;
	logic        sys_prot = 1'b0;
	logic        align_en = 1'b1;
	logic        cache_en = 1'b1;
	logic        wbuf_en = 1'b1;
	logic        wbuf_err = 1'b0;
	logic        lf_err = 1'b0;
	logic        lf_word0 = 1'b0;
	logic        ext_err = 1'b0;
	logic        walk_err_l1 = 1'b0;
	logic        walk_err_l2 = 1'b0;
	logic        err_page = 1'b0;
	// Request from the core model and response
	logic        req_valid, req_write, req_data, req_super, req_word;
	logic [31:0] req_va, l1_desc, l2_desc, resp_pa;
	logic        resp_valid, resp_abort, data_abort, prefetch_abort, mem_start;
	logic        resp_cacheable, resp_bufferable, resp_updateable, abort_info_valid;
	// Bookkeeping
	int          bad_count = 0;
	int          checks_done = 0;
	int          i;
	logic        ok;
	// Access kinds: word, write, data, super
	localparam logic [3:0] K_UR = 4'ha;
	localparam logic [3:0] K_UW = 4'he;
	localparam logic [3:0] K_SW = 4'hf;
	localparam logic [3:0] K_UF = 4'h8;
	// Page table pointers: domain 0 and domain 1, updateable set
	localparam logic [31:0] L1P  = 32'h0000_0011;
	localparam logic [31:0] L1P1 = 32'h0000_0031;
	// Small entry: sub-region k has permission k, cacheable
	localparam logic [31:0] L2S = 32'h1234_5e4a;
	// large entry, bits 15:12 zero, one copy stands for all sixteen
	localparam logic [31:0] L2L = 32'hbeef_0ff5;
	// Error cases: lf, word0, ext, walk1, walk2, page
	logic [5:0]  ev [6] = '{6'h00, 6'h08, 6'h21, 6'h30, 6'h04, 6'h02};
	logic [3:0]  ec [6] = '{FC_ALIGN, FC_BUS_SEC, FC_LF_PAGE, FC_LF_SEC, FC_WALK_L1, FC_WALK_L2};

	// Free-running clock
	always #50 clk = ~clk;

	// Core side of the access port
	mdp_core_model core (.clk(clk), .req_valid(req_valid), .req_va(req_va), .req_write(req_write),
		.req_data(req_data), .req_super(req_super), .req_word(req_word), .l1_desc(l1_desc), .l2_desc(l2_desc));

	// Block under test
	mdp_mmu_check uut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mmu_en(mmu_en), .sys_prot(sys_prot),
		.align_en(align_en), .cache_en(cache_en), .wbuf_en(wbuf_en), .req_valid(req_valid),
		.req_va(req_va), .req_write(req_write), .req_data(req_data), .req_super(req_super),
		.req_word(req_word), .l1_desc(l1_desc), .l2_desc(l2_desc), .wbuf_err(wbuf_err),
		.lf_err(lf_err), .lf_word0(lf_word0), .ext_err(ext_err), .walk_err_l1(walk_err_l1),
		.walk_err_l2(walk_err_l2), .err_page(err_page), .resp_valid(resp_valid),
		.resp_abort(resp_abort), .data_abort(data_abort), .prefetch_abort(prefetch_abort),
		.mem_start(mem_start), .resp_pa(resp_pa), .resp_cacheable(resp_cacheable),
		.resp_bufferable(resp_bufferable), .resp_updateable(resp_updateable),
		.abort_info_valid(abort_info_valid));

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic final_report;
		if (bad_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One-cycle register write
	task automatic reg_write(input logic [3:0] sel, input logic [31:0] d);
		@(posedge clk);
		#1;
		reg_wr = 1'b1;
		reg_sel = sel;
		reg_wdata = d;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
	endtask

	// Register read, data is there after the taking edge
	task automatic check_reg(input logic [3:0] sel, input logic [31:0] exp);
		@(posedge clk);
		#1;
		reg_rd = 1'b1;
		reg_sel = sel;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		check(reg_rdata, exp);
	endtask

	// One access and its one-cycle response
	task automatic run(input logic [31:0] va, l1, l2, input logic [3:0] k, input logic ab, input logic [31:0] pa);
		core.issue(va, l1, l2, k);
		check({28'h0, resp_valid, resp_abort, mem_start, data_abort}, {28'h0, 1'b1, ab, ~ab, ab & k[1]});
		check({31'h0, prefetch_abort}, {31'h0, ab & ~k[1]});
		check(resp_pa, pa);
	endtask

	// Section descriptor builder
	function automatic logic [31:0] sec(input logic [11:0] b, input logic [1:0] ap, input logic [3:0] d,
		input logic [2:0] ucb);
		sec = {b, 8'h00, ap, 1'b0, d, ucb, 2'b10};
	endfunction

	// Expected permission verdict
	function automatic logic perm_ok(input logic [1:0] ap, input logic s, sup, wr);
		case (ap)
			AP_NONE: perm_ok = s & sup & ~wr;
			AP_SUPER: perm_ok = sup;
			AP_USER_RO: perm_ok = sup | ~wr;
			default: perm_ok = 1'b1;
		endcase
	endfunction

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		final_report();
	end

	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		check_reg(REG_DOMAIN, DOMAIN_RST);
		check_reg(REG_CAUSE, {24'h0, CAUSE_RST});
		check_reg(REG_ADDR, ADDR_RST);
		reg_write(4'h9, 32'hffff_ffff);
		check_reg(4'h9, 32'h0);
		reg_write(REG_CAUSE, 32'h0000_005a);
		check_reg(REG_CAUSE, 32'h0000_005a);
		reg_write(REG_ADDR, 32'hdead_beef);
		check_reg(REG_ADDR, 32'hdead_beef);
		// Domains: 0 client, 1 none, 2 reserved, 3 manager, 5 client
		reg_write(REG_DOMAIN, 32'h0000_04e1);
		check_reg(REG_DOMAIN, 32'h0000_04e1);
		// Every permission code, S bit, privilege and direction
		for (i = 0; i < 32; i++)
		begin
			sys_prot = i[1];
			ok = perm_ok(i[3:2], i[1], i[0], i[4]);
			run(32'h0012_3458, sec(12'hab1, i[3:2], 4'h5, 3'b101), 32'h0, {1'b1, i[4], 1'b1, i[0]}, !ok,
				ok ? 32'hab12_3458 : 32'h0);
			check({29'h0, resp_updateable, resp_cacheable, resp_bufferable}, {29'h0, ok, 1'b0, ok});
			if (!ok)
				check_reg(REG_CAUSE, {24'h0, 4'h5, FC_PERM_SEC});
		end
		sys_prot = 1'b0;
		// Every domain code with a denying permission field
		for (i = 0; i < 4; i++)
		begin
			run(32'h0002_3458, sec(12'h3c0, 2'h0, i[3:0], 3'b000), 32'h0, K_UW, i != 3,
				i == 3 ? 32'h3c02_3458 : 32'h0);
			if (i != 3)
				check_reg(REG_CAUSE, {24'h0, i[3:0], i == 0 ? FC_PERM_SEC : FC_DOM_SEC});
		end
		// Attributes gated off
		cache_en = 1'b0;
		wbuf_en = 1'b0;
		run(32'h0002_3458, sec(12'h3c0, 2'h0, 4'h3, 3'b111), 32'h0, K_UW, 1'b0, 32'h3c02_3458);
		check({29'h0, resp_updateable, resp_cacheable, resp_bufferable}, 32'h0);
		cache_en = 1'b1;
		wbuf_en = 1'b1;
		// Small page, every sub-region, user read
		for (i = 0; i < 4; i++)
			run({20'h0, i[1:0], 10'h010}, L1P, L2S, K_UR, i < 2, i < 2 ? 32'h0 : {20'h12345, i[1:0], 10'h010});
		check({29'h0, resp_updateable, resp_cacheable, resp_bufferable}, 32'h6);
		check_reg(REG_CAUSE, {24'h0, 4'h0, FC_PERM_PG});
		// Large page
		run(32'h0000_c234, L1P, L2L, K_SW, 1'b0, 32'hbeef_c234);
		check({29'h0, resp_updateable, resp_cacheable, resp_bufferable}, 32'h5);
		// Invalid and reserved second-level entries
		run(32'h0000_0100, L1P, 32'h0, K_UR, 1'b1, 32'h0);
		check_reg(REG_CAUSE, {24'h0, 4'h0, FC_TR_PAGE});
		run(32'h0000_0100, L1P1, 32'h3, K_UR, 1'b1, 32'h0);
		check_reg(REG_CAUSE, {24'h0, 4'h1, FC_TR_PAGE});
		// Invalid first level entry keeps its domain bits
		run(32'h0345_6780, 32'h0000_0140, 32'h0, K_UR, 1'b1, 32'h0);
		check_reg(REG_CAUSE, {24'h0, 4'ha, FC_TR_SEC});
		check_reg(REG_ADDR, 32'h0345_6780);
		// Fetch abort leaves the records alone
		run(32'h0777_0000, 32'h0000_0063, 32'h0, K_UF, 1'b1, 32'h0);
		check_reg(REG_CAUSE, {24'h0, 4'ha, FC_TR_SEC});
		check_reg(REG_ADDR, 32'h0345_6780);
		// Coinciding sources under a domain fault
		for (i = 0; i < 6; i++)
		begin
			{lf_err, lf_word0, ext_err, walk_err_l1, walk_err_l2, err_page} = ev[i];
			run(i < 4 ? 32'h0012_3459 : 32'h0012_3458, i == 5 ? L1P1 : sec(12'h100, 2'h3, 4'h1, 3'b000),
				L2S, K_UR, 1'b1, 32'h0);
			check({31'h0, abort_info_valid}, {31'h0, i != 2});
			check_reg(REG_CAUSE, {24'h0, 4'h1, ec[i]});
		end
		{lf_err, lf_word0, ext_err, walk_err_l1, walk_err_l2, err_page} = 6'h00;
		// Byte access skips the alignment check
		run(32'h0012_3459, sec(12'h100, 2'h3, 4'h1, 3'b000), 32'h0, 4'h2, 1'b1, 32'h0);
		check_reg(REG_CAUSE, {24'h0, 4'h1, FC_DOM_SEC});
		// Alignment check off, then translation off
		align_en = 1'b0;
		run(32'h0012_3459, sec(12'h100, 2'h3, 4'h3, 3'b000), 32'h0, K_UR, 1'b0, 32'h1002_3459);
		align_en = 1'b1;
		mmu_en = 1'b0;
		run(32'h0345_6780, 32'h0000_0140, 32'h0, K_UR, 1'b0, 32'h0345_6780);
		mmu_en = 1'b1;
		// Buffered write error: fetch passes, next data access takes it
		@(posedge clk);
		#1;
		wbuf_err = 1'b1;
		@(posedge clk);
		#1;
		wbuf_err = 1'b0;
		run(32'h0004_5670, sec(12'h7f0, 2'h3, 4'h0, 3'b000), 32'h0, K_UF, 1'b0, 32'h7f04_5670);
		run(32'h0004_5670, sec(12'h7f0, 2'h3, 4'h0, 3'b000), 32'h0, K_UR, 1'b1, 32'h0);
		check_reg(REG_CAUSE, {24'h0, 4'h0, FC_WBUF});
		check_reg(REG_ADDR, 32'h0004_5670);
		run(32'h0004_5674, sec(12'h7f0, 2'h3, 4'h0, 3'b000), 32'h0, K_UR, 1'b0, 32'h7f04_5674);
		final_report();
	end
endmodule
